// ===== common/dma_arb_pkg.sv
// Constants, register map and state encoding for the DMA channel arbiter
// Operation
// - Round-robin level records last granted channel
// - Static level ignores recorded last-granted value
// - Disabling round-robin keeps last-granted field
// - Enable bit: zero static, one round-robin
// - Descriptor next pointer gives next fetch address
// - All-zero next pointer terminates the transaction
// - Pending register names lowest interrupting channel
package dma_arb_pkg;
	localparam int N_CH = 16;
	localparam int CH_W = 4;
	localparam int N_LVL = 3;
	localparam int LVL_W = 2;
	localparam int AW = 12;
	// Register byte offsets
	localparam logic [AW-1:0] CTRL_OFF = 12'h000;
	localparam logic [AW-1:0] BASE_OFF = 12'h004;
	localparam logic [AW-1:0] STAT_OFF = 12'h008;
	localparam logic [AW-1:0] PEND_OFF = 12'h020;
	// Control field layout per level
	localparam int LVL_STRIDE = 8;
	localparam int RR_EN_OFS = 7;
	localparam int LAST_OFS = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] BASE_RESET = 32'h0000_0000;
	localparam logic [15:0] PEND_RESET = 16'h0000;
	localparam int PEND_ANY_BIT = 15;
	// Descriptor layout
	localparam logic [31:0] DESC_BYTES = 32'h0000_0010;
	localparam logic [31:0] NEXT_PTR_OFS = 32'h0000_000c;
	localparam logic [31:0] ALIGN_MASK = 32'h0000_000f;
	localparam logic [31:0] NULL_PTR = 32'h0000_0000;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_ARB = 2'b00,
		ST_FETCH = 2'b01,
		ST_WAIT = 2'b10,
		ST_DONE = 2'b11
	} arb_state_e;
endpackage

// ===== hdl/dma_channel_arbitration.sv
// Channel arbiter, descriptor chain walker and register slave
`timescale 1ns/10ps
module dma_channel_arbitration (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Register bus
	input wire logic [dma_arb_pkg::AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dma_arb_pkg::AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Channel requests and interrupts
	input wire logic [dma_arb_pkg::N_CH-1:0] ch_req,
	input wire logic [dma_arb_pkg::N_CH*dma_arb_pkg::LVL_W-1:0] ch_level,
	input wire logic [dma_arb_pkg::N_CH-1:0] ch_irq,
	// Grant
	output logic grant_valid,
	output logic [dma_arb_pkg::CH_W-1:0] grant_channel,
	output logic chain_done,
	// Descriptor memory read port
	output logic desc_rd_req,
	output logic [31:0] desc_rd_addr,
	input wire logic desc_rd_valid,
	input wire logic [31:0] desc_rd_data
);
	import dma_arb_pkg::*;

	logic [31:0] ctrl_reg;
	logic [31:0] base_reg;
	logic [15:0] pend_reg;
	arb_state_e state_reg;
	logic [31:0] cur_desc_reg;
	logic [N_LVL-1:0] rr_en;
	logic [CH_W-1:0] last_g [N_LVL];
	logic [N_CH-1:0] lvl_mask [N_LVL];
	logic [N_LVL-1:0] lvl_any;
	logic [CH_W-1:0] lvl_pick [N_LVL];
	logic [CH_W-1:0] lvl_low [N_LVL];
	logic sel_any;
	logic [LVL_W-1:0] sel_lvl;
	logic [CH_W-1:0] sel_ch;
	logic [CH_W-1:0] sel_low;
	logic wr_go;
	logic rd_go;
	logic [CH_W-1:0] irq_low;
	logic [31:0] next_ptr;

	// Search from start upward, wrapping after the top channel
	function automatic logic [CH_W-1:0] pick(input logic [N_CH-1:0] m,
			input logic [CH_W-1:0] start);
		logic [CH_W-1:0] r;
		logic found;
		logic [CH_W-1:0] idx;
		r = '0;
		found = 1'b0;
		for (int i = 0; i < N_CH; i++) begin
			idx = CH_W'(32'(start) + i);
			if (!found && m[idx]) begin
				r = idx;
				found = 1'b1;
			end
		end
		return r;
	endfunction

	// Per-level candidates
	for (genvar l = 0; l < N_LVL; l++) begin : g_lvl
		assign rr_en[l] = ctrl_reg[l*LVL_STRIDE+RR_EN_OFS];
		assign last_g[l] = ctrl_reg[l*LVL_STRIDE+LAST_OFS +: CH_W];
		for (genvar c = 0; c < N_CH; c++) begin : g_ch
			assign lvl_mask[l][c] = ch_req[c] &&
				(ch_level[c*LVL_W +: LVL_W] == LVL_W'(l));
		end
		assign lvl_any[l] = |lvl_mask[l];
		assign lvl_low[l] = pick(lvl_mask[l], '0);
		// Static ignores the recorded field
		assign lvl_pick[l] = rr_en[l] ?
			pick(lvl_mask[l], CH_W'(32'(last_g[l]) + 1)) : lvl_low[l];
	end

	// Highest requesting level wins
	always_comb begin
		sel_any = 1'b0;
		sel_lvl = '0;
		sel_ch = '0;
		sel_low = '0;
		for (int l = 0; l < N_LVL; l++) begin
			if (lvl_any[l]) begin
				sel_any = 1'b1;
				sel_lvl = LVL_W'(l);
				sel_ch = lvl_pick[l];
				sel_low = lvl_low[l];
			end
		end
	end

	assign irq_low = pick(ch_irq, '0);
	assign next_ptr = desc_rd_data & ~ALIGN_MASK;
	assign wr_go = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	// Bus write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid &&
				!s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid &&
				!s_axi_awready && !s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr == CTRL_OFF ||
					s_axi_awaddr == BASE_OFF || s_axi_awaddr == STAT_OFF ||
					s_axi_awaddr == PEND_OFF) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Bus read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
				!s_axi_rvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				case (s_axi_araddr)
					CTRL_OFF: s_axi_rdata <= ctrl_reg;
					BASE_OFF: s_axi_rdata <= base_reg;
					STAT_OFF: s_axi_rdata <= cur_desc_reg;
					PEND_OFF: s_axi_rdata <= {16'h0000, pend_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control register: software sets enables, hardware the fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_RESET;
			base_reg <= BASE_RESET;
		end else if (ce) begin
			if (wr_go && s_axi_awaddr == CTRL_OFF && s_axi_wstrb == 4'hf) begin
				for (int l = 0; l < N_LVL; l++) begin
					// Field left alone on enable change
					ctrl_reg[l*LVL_STRIDE+RR_EN_OFS] <=
						s_axi_wdata[l*LVL_STRIDE+RR_EN_OFS];
				end
			end
			if (wr_go && s_axi_awaddr == BASE_OFF && s_axi_wstrb == 4'hf) begin
				base_reg <= s_axi_wdata & ~ALIGN_MASK;
			end
			if (state_reg == ST_ARB && sel_any && rr_en[sel_lvl]) begin
				ctrl_reg[32'(sel_lvl)*LVL_STRIDE+LAST_OFS +: CH_W] <=
					sel_ch;
			end
		end
	end

	// Pending interrupt register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_reg <= PEND_RESET;
		end else if (ce) begin
			pend_reg <= PEND_RESET;
			pend_reg[PEND_ANY_BIT] <= |ch_irq;
			pend_reg[CH_W-1:0] <= irq_low;
		end
	end

	// Grant and descriptor chain walk
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_ARB;
			grant_valid <= 1'b0;
			grant_channel <= '0;
			chain_done <= 1'b0;
			desc_rd_req <= 1'b0;
			desc_rd_addr <= 32'h0000_0000;
			cur_desc_reg <= 32'h0000_0000;
		end else if (ce) begin
			chain_done <= 1'b0;
			case (state_reg)
				ST_ARB: begin
					if (sel_any) begin
						grant_valid <= 1'b1;
						grant_channel <= sel_ch;
						cur_desc_reg <= base_reg + DESC_BYTES * 32'(sel_ch);
						state_reg <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					desc_rd_req <= 1'b1;
					desc_rd_addr <= cur_desc_reg + NEXT_PTR_OFS;
					state_reg <= ST_WAIT;
				end
				ST_WAIT: begin
					if (desc_rd_valid) begin
						desc_rd_req <= 1'b0;
						if (desc_rd_data == NULL_PTR) begin
							chain_done <= 1'b1;
							grant_valid <= 1'b0;
							state_reg <= ST_DONE;
						end else begin
							cur_desc_reg <= next_ptr;
							state_reg <= ST_FETCH;
						end
					end
				end
				ST_DONE: state_reg <= ST_ARB;
				default: state_reg <= ST_ARB;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic arb_go;
	assign arb_go = ce && state_reg == ST_ARB && sel_any;

	rr_record_a: assert property (arb_go && rr_en[sel_lvl] |=>
		ctrl_reg[32'($past(sel_lvl))*LVL_STRIDE +: CH_W] == grant_channel)
		else $error("last-granted field not updated");
	static_order_a: assert property (arb_go && !rr_en[sel_lvl] |=>
		grant_channel == $past(sel_low))
		else $error("static grant not lowest requester");
	field_hold_a: assert property (
		!(arb_go && rr_en[sel_lvl]) |=> $stable(ctrl_reg[3:0]) ||
		$past(sel_lvl) != 2'h0)
		else $error("level 0 field changed without grant");
	enable_write_a: assert property (ce && wr_go &&
		s_axi_awaddr == CTRL_OFF && s_axi_wstrb == 4'hf |=>
		rr_en[1] == $past(s_axi_wdata[15]) &&
		rr_en[0] == $past(s_axi_wdata[7]))
		else $error("enable bits not written");
	desc_follow_a: assert property (ce && state_reg == ST_WAIT &&
		desc_rd_valid && desc_rd_data != NULL_PTR
		|=> ##1 desc_rd_req && desc_rd_addr == $past(next_ptr, 2) + NEXT_PTR_OFS)
		else $error("next descriptor not fetched");
	null_stop_a: assert property (ce && state_reg == ST_WAIT &&
		desc_rd_valid && desc_rd_data == NULL_PTR
		|=> chain_done && !desc_rd_req && !grant_valid)
		else $error("null pointer did not terminate");
	pend_low_a: assert property (ce && ch_irq != 16'h0000 |=>
		pend_reg[CH_W-1:0] == $past(irq_low) && pend_reg[PEND_ANY_BIT])
		else $error("pending register wrong");
	rr_next_a: assert property (arb_go && rr_en[sel_lvl] &&
		lvl_mask[sel_lvl][CH_W'(32'(last_g[sel_lvl]) + 1)]
		|=> grant_channel == $past(CH_W'(32'(last_g[sel_lvl]) + 1)))
		else $error("round-robin skipped next requester");
	static_low_a: assert property (arb_go && !rr_en[sel_lvl] &&
		ch_req[0] && ch_level[1:0] == sel_lvl |=> grant_channel == 4'h0)
		else $error("channel 0 not preferred");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid)
		else $error("write response dropped");

	chain_cov: cover property (chain_done);
	rr_cov: cover property (arb_go && rr_en[sel_lvl]);
	link_cov: cover property (state_reg == ST_WAIT && desc_rd_valid &&
		desc_rd_data != NULL_PTR);
	err_cov: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

// ===== test/desc_mem_model.sv
// Descriptor memory model answering next-pointer reads
`timescale 1ns/10ps
module desc_mem_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Descriptor read port
	input wire logic desc_rd_req,
	input wire logic [31:0] desc_rd_addr,
	output logic desc_rd_valid,
	output logic [31:0] desc_rd_data,
	// Answer delay in cycles
	input wire logic [3:0] lag
);
	logic [31:0] mem [64] = '{default: 32'h0};
	logic [3:0] cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 4'h0;
			desc_rd_valid <= 1'b0;
			desc_rd_data <= 32'h0;
		end else begin
			desc_rd_valid <= 1'b0;
			desc_rd_data <= ~desc_rd_data; // Idle bus toggles
			if (desc_rd_req && !desc_rd_valid) begin
				cnt <= (cnt == lag) ? 4'h0 : cnt + 4'h1;
				if (cnt == lag) begin
					desc_rd_valid <= 1'b1;
					desc_rd_data <= mem[desc_rd_addr[9:4]];
				end
			end
		end
	end
endmodule

// ===== test/dma_channel_arbitration_tb.sv
// Self-checking bench for the DMA channel arbiter
`timescale 1ns/10ps
module dma_channel_arbitration_tb;
	import dma_arb_pkg::*;
	logic aclk, aresetn = 1'b0, ce = 1'b1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic grant_valid, chain_done, desc_rd_req, desc_rd_valid;
	logic [AW-1:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, desc_rd_addr;
	logic [31:0] desc_rd_data, rd, a0, a1;
	logic [3:0] s_axi_wstrb = 4'hf, lag = 4'h0;
	logic [CH_W-1:0] grant_channel, g;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [N_CH-1:0] ch_req = 16'h0, ch_irq = 16'h0;
	logic [2*N_CH-1:0] ch_level = 32'h0;
	int num_errors = 0, n_compared = 0;
	dma_channel_arbitration dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.ch_req(ch_req),
		.ch_level(ch_level),
		.ch_irq(ch_irq),
		.grant_valid(grant_valid),
		.grant_channel(grant_channel),
		.chain_done(chain_done),
		.desc_rd_req(desc_rd_req),
		.desc_rd_addr(desc_rd_addr),
		.desc_rd_valid(desc_rd_valid),
		.desc_rd_data(desc_rd_data)
	);
	desc_mem_model mem_u (
		.aclk(aclk),
		.aresetn(aresetn),
		.desc_rd_req(desc_rd_req),
		.desc_rd_addr(desc_rd_addr),
		.desc_rd_valid(desc_rd_valid),
		.desc_rd_data(desc_rd_data),
		.lag(lag)
	);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic lim(input int i);
		num_errors += int'(i >= 60);
		if (i >= 60)
			close_out;
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d);
		int i = 0;
		{s_axi_awaddr, s_axi_araddr} <= {a[11:0], a[11:0]};
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
		{s_axi_bready, s_axi_rready} <= {w, !w};
		do begin
			@(posedge aclk);
			i++;
			if ((w ? s_axi_awready : s_axi_arready) === 1'b1)
				{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
		end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && i < 60);
		{s_axi_bready, s_axi_rready} <= 2'h0;
		rd = s_axi_rdata;
		rs = w ? s_axi_bresp : s_axi_rresp;
		lim(i);
		// Idle edge so the next call never re-drives the readies at once
		@(posedge aclk);
	endtask
	task automatic serve;
		int i = 0;
		do begin
			@(posedge aclk);
			i++;
			g = grant_channel;
		end while (desc_rd_req !== 1'b1 && i < 60);
		a0 = desc_rd_addr;
		do begin
			@(posedge aclk);
			i++;
			if (desc_rd_req === 1'b1)
				a1 = desc_rd_addr;
		end while (chain_done !== 1'b1 && i < 60);
		lim(i);
	endtask
	task automatic regs_reset;
		bus(1'b0, CTRL_OFF, 32'h0);
		check(rd, CTRL_RESET);
		bus(1'b0, PEND_OFF, 32'h0);
		check(rd, {16'h0, PEND_RESET});
		bus(1'b1, 32'h100, 32'h1);
		check(rs, RESP_SLVERR);
		bus(1'b0, 32'h100, 32'h0);
		check(rs, RESP_SLVERR);
		check(rd, 32'h0);
	endtask
	task automatic static_chain;
		bus(1'b1, BASE_OFF, 32'h100);
		check(rs, RESP_OKAY);
		mem_u.mem[16] = 32'h200;
		lag <= 4'h3;
		ch_req <= 16'h0025;
		serve;
		ch_req <= 16'h0;
		check(g, 32'h0);
		check(a0, 32'h10c);
		check(a1, 32'h20c);
		check(grant_valid, 1'b0);
		bus(1'b0, STAT_OFF, 32'h0);
		check(rd, 32'h200);
	endtask
	task automatic round_robin;
		bus(1'b1, CTRL_OFF, 32'h8080);
		ch_level <= 32'h0410;
		ch_req <= 16'h0024;
		serve;
		check(g, 32'h2);
		serve;
		ch_req <= 16'h0;
		check(g, 32'h5);
		bus(1'b0, CTRL_OFF, 32'h0);
		check(rd[15:8], 8'h85);
		ch_req <= 16'h0024;
		serve;
		ch_req <= 16'h0;
		check(g, 32'h2);
	endtask
	task automatic rr_off;
		ch_irq <= 16'h0210;
		bus(1'b1, CTRL_OFF, 32'h0);
		bus(1'b0, CTRL_OFF, 32'h0);
		check(rd[15:8], 8'h02);
		ch_req <= 16'h0024;
		serve;
		ch_req <= 16'h0;
		check(g, 32'h2);
		bus(1'b0, PEND_OFF, 32'h0);
		check(rd, 32'h8004);
	endtask
	task automatic hold_off;
		ce <= 1'b0;
		ch_req <= 16'h0024;
		repeat (4) @(posedge aclk);
		check(grant_valid, 1'b0);
		ce <= 1'b1;
		serve;
		ch_req <= 16'h0;
		check(g, 32'h2);
	endtask
	task automatic top_level;
		bus(1'b1, CTRL_OFF, 32'h0080_0000);
		ch_level <= 32'h0818;
		ch_req <= 16'h0026;
		serve;
		check(g, 32'h1);
		serve;
		ch_req <= 16'h0;
		check(g, 32'h5);
		bus(1'b0, CTRL_OFF, 32'h0);
		check(rd[23:16], 8'h85);
		check(rd[15:8], 8'h02);
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		regs_reset;
		static_chain;
		round_robin;
		rr_off;
		hold_off;
		top_level;
		close_out;
	end
endmodule
